// *** core/pmr_top.sv ***
// pmr_top: program counter, table pointer, table read engine, serial pin mux
// assumes core pulses requests one cycle; serial link is sampled on i_mclk
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - memory is 4K words of 16 bits
// - fetches addressed by program counter
// - table data addressed by separate pointer
// - reset loads program counter with 0000H
// - pointer low and high form address
// - sector 0 standard, else far op for far opcodes only
// - low byte goes to named register
// - high byte goes to table_high_byte
// - unimplemented high bits read zero
// - address from low 12 bits of pointer, page 0FH for last-page ops
// - table_high_byte readable and writable by software
// - table instructions take two cycles
// - programming serial data two-way, external clock
// - debug uses data pin and clock input
// - shared pin functions inert while debugging
// - debug pins still serve programming
module pmr_top
  import pmr_pkg::*;
#(
  parameter int ADDR_W = PMR_ADDR_W,
  parameter int WORD_W = PMR_WORD_W
) (
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // fetch side
  input  wire logic               i_pc_inc,
  input  wire logic               i_pc_load,
  input  wire logic [ADDR_W-1:0]  i_pc_value,
  output logic      [ADDR_W-1:0]  o_pc,
  output logic      [WORD_W-1:0]  o_instr,
  // table pointer writes
  input  wire logic               i_tblp_wr,
  input  wire logic               i_tbhp_wr,
  input  wire logic [7:0]         i_ptr_data,
  output logic      [7:0]         o_tblp,
  output logic      [7:0]         o_tbhp,
  // table_high_byte access
  input  wire logic               i_table_high_byte_wr,
  input  wire logic [7:0]         i_table_high_byte_data,
  output logic      [7:0]         o_table_high_byte,
  // table read
  input  wire logic               i_tbl_req,
  input  wire pmr_tbl_req_t       i_tbl_cmd,
  output logic                    o_tbl_busy,
  output logic                    o_tbl_wr,
  output pmr_tbl_wr_t             o_tbl_wr_data,
  output logic                    o_tbl_far,
  // serial pins, then the program memory write port
  input  wire logic               i_debug_mode,
  input  wire logic               i_prog_mode,
  input  wire logic               i_prog_serial_data,
  input  wire logic               i_prog_serial_clock,
  input  wire logic               i_prog_drive,
  input  wire logic               i_prog_dout,
  output logic                    o_prog_serial_data,
  output logic                    o_prog_serial_data_oe,
  output logic                    o_prog_clk_seen,
  input  wire logic               i_func_dout,
  input  wire logic               i_func_oe,
  output logic                    o_func_din,
  output logic                    o_func_clk_din,
  input  wire logic               i_mem_wr_en,
  input  wire logic [ADDR_W-1:0]  i_mem_wr_addr,
  input  wire logic [WORD_W-1:0]  i_mem_wr_data
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_DONE
  } pmr_state_t;

  pmr_state_t        state_q;
  logic [ADDR_W-1:0] pc_q;
  logic [ADDR_W-1:0] pc_d;
  logic [7:0]        tblp_q;
  logic [7:0]        tbhp_q;
  logic [7:0]        table_high_byte_q;
  pmr_tbl_req_t      cmd_q;
  pmr_op_t           op_sel;
  logic [ADDR_W-1:0] tbl_addr;
  logic [WORD_W-1:0] fetch_word;
  logic [WORD_W-1:0] tbl_word;
  logic [7:0]        hi_byte;
  logic              pin_shared;

  ////////////////////////////////////////////////////////////////////////////
  // word address from the pointer pair, upper high bits dropped
  function automatic logic [ADDR_W-1:0] ptr_addr(input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] full;
    full     = {hi, lo};
    ptr_addr = full[ADDR_W-1:0];
  endfunction : ptr_addr

  function automatic logic is_last_page(input pmr_op_t op);
    is_last_page = (op == PMR_OP_TABRD_LAST) || (op == PMR_OP_FAR_LAST);
  endfunction : is_last_page

  function automatic logic is_far(input pmr_tbl_req_t c);
    is_far = (c.op == PMR_OP_FAR) || (c.op == PMR_OP_FAR_LAST);
  endfunction : is_far

  ////////////////////////////////////////////////////////////////////////////
  // program counter
  always_comb begin
    pc_d = pc_q;
    if (i_pc_load) begin
      pc_d = i_pc_value;
    end else if (i_pc_inc) begin
      pc_d = pc_q + 12'h001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pc_q <= PMR_RESET_VECTOR;
    end else begin
      pc_q <= pc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table pointer
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tblp_q <= 8'h00;
      tbhp_q <= 8'h00;
    end else begin
      if (i_tblp_wr) begin
        tblp_q <= i_ptr_data;
      end
      if (i_tbhp_wr) begin
        tbhp_q <= i_ptr_data;
      end
    end
  end

  // last-page ops use the last page in place of the high pointer
  // op from the request while idle: memory reads on the taking edge
  always_comb begin
    op_sel = (state_q == ST_IDLE) ? i_tbl_cmd.op : cmd_q.op;
    if (is_last_page(op_sel)) begin
      tbl_addr = ptr_addr(PMR_LAST_PAGE, tblp_q);
    end else begin
      tbl_addr = ptr_addr(tbhp_q, tblp_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory
  pmr_mem #(
    .ADDR_W (ADDR_W),
    .WORD_W (WORD_W),
    .DEPTH  (PMR_DEPTH)
  ) u_mem (
    .i_mclk       (i_mclk),
    .i_fetch_addr (pc_q),
    .o_fetch_data (fetch_word),
    .i_tbl_addr   (tbl_addr),
    .o_tbl_data   (tbl_word),
    .i_wr_en      (i_mem_wr_en),
    .i_wr_addr    (i_mem_wr_addr),
    .i_wr_data    (i_mem_wr_data)
  );

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_instr <= '0;
    end else begin
      o_instr <= fetch_word;
    end
  end

  // high byte zero-filled above the word width
  always_comb begin
    hi_byte = 8'h00;
    hi_byte[WORD_W-9:0] = tbl_word[WORD_W-1:8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // table read engine: request, memory read, write back
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      cmd_q   <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (i_tbl_req) begin
            cmd_q   <= i_tbl_cmd;
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_tbl_wr      <= 1'b0;
      o_tbl_wr_data <= '0;
      o_tbl_far     <= 1'b0;
    end else begin
      o_tbl_wr <= (state_q == ST_READ);
      if (state_q == ST_READ) begin
        o_tbl_wr_data.sector    <= cmd_q.sector;
        o_tbl_wr_data.dest_addr <= cmd_q.dest_addr;
        o_tbl_wr_data.data      <= tbl_word[7:0];
        o_tbl_far <= is_far(cmd_q) && (cmd_q.sector != PMR_SECTOR0);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_tbl_busy <= 1'b0;
    end else begin
      o_tbl_busy <= (state_q == ST_IDLE) ? i_tbl_req : (state_q == ST_READ);
    end
  end

  // table write-back wins over a software write in the same cycle
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      table_high_byte_q <= PMR_TABLE_HIGH_BYTE_RESET;
    end else if (state_q == ST_READ) begin
      table_high_byte_q <= hi_byte;
    end else if (i_table_high_byte_wr) begin
      table_high_byte_q <= i_table_high_byte_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_pc              <= PMR_RESET_VECTOR;
      o_tblp            <= 8'h00;
      o_tbhp            <= 8'h00;
      o_table_high_byte <= PMR_TABLE_HIGH_BYTE_RESET;
    end else begin
      o_pc              <= pc_d;
      o_tblp            <= i_tblp_wr ? i_ptr_data : tblp_q;
      o_tbhp            <= i_tbhp_wr ? i_ptr_data : tbhp_q;
      o_table_high_byte <= (state_q == ST_READ) ? hi_byte : (i_table_high_byte_wr ? i_table_high_byte_data : table_high_byte_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial pin sharing
  assign pin_shared = i_debug_mode || i_prog_mode;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_prog_serial_data    <= 1'b0;
      o_prog_serial_data_oe <= 1'b0;
      o_prog_clk_seen       <= 1'b0;
      o_func_din            <= 1'b0;
      o_func_clk_din        <= 1'b0;
    end else if (pin_shared) begin
      o_prog_serial_data    <= i_prog_dout;
      o_prog_serial_data_oe <= i_prog_drive;
      o_prog_clk_seen       <= i_prog_serial_clock;
      o_func_din            <= 1'b0;
      o_func_clk_din        <= 1'b0;
    end else begin
      o_prog_serial_data    <= i_func_dout;
      o_prog_serial_data_oe <= i_func_oe;
      o_prog_clk_seen       <= 1'b0;
      o_func_din            <= i_prog_serial_data;
      o_func_clk_din        <= i_prog_serial_clock;
    end
  end

endmodule : pmr_top

// *** core/pmr_pkg.sv ***
// pmr_pkg: constants and carrier types for the program memory table reader
// assumes one core clock domain; core issues fetch and table requests
package pmr_pkg;

  localparam int          PMR_ADDR_W       = 12;
  localparam int          PMR_WORD_W       = 16;
  localparam int          PMR_DEPTH        = 4096;
  localparam logic [11:0] PMR_RESET_VECTOR = 12'h000;
  localparam logic [7:0]  PMR_TABLE_HIGH_BYTE_RESET   = 8'h00;
  localparam logic [2:0]  PMR_SECTOR0      = 3'h0;
  localparam int          PMR_TBL_CYCLES   = 2;
  localparam logic [1:0]  PMR_TBL_LAST     = 2'h1;
  localparam logic [7:0]  PMR_LAST_PAGE    = 8'h0f;

  typedef enum logic [1:0] {
    PMR_OP_TABRD,
    PMR_OP_TABRD_LAST,
    PMR_OP_FAR,
    PMR_OP_FAR_LAST
  } pmr_op_t;

  // table read request from the core
  typedef struct packed {
    pmr_op_t     op;
    logic [2:0]  sector;
    logic [7:0]  dest_addr;
  } pmr_tbl_req_t;

  // table read answer toward the data memory
  typedef struct packed {
    logic [2:0]  sector;
    logic [7:0]  dest_addr;
    logic [7:0]  data;
  } pmr_tbl_wr_t;

  // serial pin output pair
  typedef struct packed {
    logic o;
    logic oe;
  } pmr_pin_out_t;

endpackage : pmr_pkg

// *** core/pmr_mem.sv ***
// pmr_mem: instruction memory array, one fetch port and one table port
// assumes synchronous read; writes come from the programming side
`timescale 1ns/1ps
module pmr_mem
  import pmr_pkg::*;
#(
  parameter int ADDR_W = PMR_ADDR_W,
  parameter int WORD_W = PMR_WORD_W,
  parameter int DEPTH  = PMR_DEPTH
) (
  input  wire logic              i_mclk,
  input  wire logic [ADDR_W-1:0] i_fetch_addr,
  output logic      [WORD_W-1:0] o_fetch_data,
  input  wire logic [ADDR_W-1:0] i_tbl_addr,
  output logic      [WORD_W-1:0] o_tbl_data,
  input  wire logic              i_wr_en,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [WORD_W-1:0] i_wr_data
);

  logic [WORD_W-1:0] mem [DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    o_fetch_data <= mem[i_fetch_addr];
  end

  always_ff @(posedge i_mclk) begin
    o_tbl_data <= mem[i_tbl_addr];
  end

endmodule : pmr_mem

// *** testbench/pmr_top_properties.sv ***
// pmr_top_properties: port timing checks for pmr_top
// assumes binding into pmr_top, one clock domain
`timescale 1ns/1ps
module pmr_top_properties
  import pmr_pkg::*;
(
  input wire logic         i_mclk,
  input wire logic         i_rst_n,
  input wire logic         i_pc_inc,
  input wire logic         i_pc_load,
  input wire logic [11:0]  i_pc_value,
  input wire logic [11:0]  o_pc,
  input wire logic         i_table_high_byte_wr,
  input wire logic [7:0]   i_table_high_byte_data,
  input wire logic [7:0]   o_table_high_byte,
  input wire logic         i_tbl_req,
  input wire pmr_tbl_req_t i_tbl_cmd,
  input wire logic         o_tbl_busy,
  input wire logic         o_tbl_wr,
  input wire logic         o_tbl_far,
  input wire logic         i_debug_mode,
  input wire logic         o_func_din
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
////////////////////////////////////////
  sequence take_s;
    i_tbl_req && !o_tbl_busy && !o_tbl_wr;
  endsequence
  sequence answer_s;
    o_tbl_busy && !o_tbl_wr ##1 o_tbl_wr && o_tbl_busy ##1 !o_tbl_busy && !o_tbl_wr;
  endsequence
  table_timing_a: assert property (take_s |=> answer_s) else $error("table read late");
  wr_pulse_a: assert property (o_tbl_wr |=> !o_tbl_wr) else $error("write pulse long");
  far_flag_a: assert property (o_tbl_wr |-> o_tbl_far ==
    ($past(i_tbl_cmd.op[1], 2) && $past(i_tbl_cmd.sector, 2) != PMR_SECTOR0)) else $error("far flag");
  reset_entry_a: assert property (disable iff (1'b0) !i_rst_n |=> o_pc == PMR_RESET_VECTOR)
    else $error("reset entry");
  pc_load_a: assert property (i_pc_load |=> o_pc == $past(i_pc_value)) else $error("pc load");
  pc_step_a: assert property (i_pc_inc && !i_pc_load |=> o_pc == $past(o_pc) + 12'h1)
    else $error("pc step");
  table_high_byte_sw_a: assert property (i_table_high_byte_wr && !o_tbl_busy |=> o_table_high_byte == $past(i_table_high_byte_data))
    else $error("table_high_byte write");
  shared_mute_a: assert property (i_debug_mode [*2] |-> !o_func_din) else $error("shared pin live");
endmodule : pmr_top_properties

bind pmr_top pmr_top_properties u_pmr_top_properties (.*);

// *** testbench/pmr_core_model.sv ***
// pmr_core_model: core side issuing table read requests
// assumes the bench pulses i_go with the command held on i_cmd
`timescale 1ns/1ps
module pmr_core_model
  import pmr_pkg::*;
(
  input  wire logic         i_mclk,
  input  wire logic         i_go,
  input  wire logic         i_dup,
  input  wire pmr_tbl_req_t i_cmd,
  input  wire logic         i_busy,
  input  wire logic         i_wr,
  output logic              o_req,
  output pmr_tbl_req_t      o_cmd
);
  logic pend = 0;
  logic again = 0;
  initial o_req = 0;
  initial o_cmd = '0;
  always @(posedge i_mclk) begin
    if (i_go) pend = 1;
    #1;
    if (pend && !i_busy && !i_wr) begin
      o_req = 1;
      o_cmd = i_cmd;
      pend = 0;
      again = i_dup;
    end else begin
      o_req = again;
      again = 0;
    end
  end
endmodule : pmr_core_model

// *** testbench/test_program_memory_table_reader.sv ***
// test_program_memory_table_reader: self-checking bench for pmr_top
// assumes pmr_pkg, pmr_top, the core model and the bound checker
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module test_program_memory_table_reader;
  import pmr_pkg::*;
  logic i_mclk, i_rst_n, i_pc_inc, i_pc_load, i_tblp_wr, i_tbhp_wr, i_table_high_byte_wr, i_tbl_req, i_mem_wr_en;
  logic i_debug_mode, i_prog_mode, i_prog_serial_data, i_prog_serial_clock, go, dup;
  logic o_tbl_busy, o_tbl_wr, o_tbl_far, o_prog_serial_data, o_prog_serial_data_oe;
  logic o_prog_clk_seen, o_func_din, o_func_clk_din;
  logic i_prog_drive, i_prog_dout, i_func_dout, i_func_oe;
  logic [11:0] i_pc_value, o_pc, i_mem_wr_addr, a;
  logic [11:0] fa [4] = '{12'h000, 12'h7ff, 12'hf06, 12'hfff};
  logic [15:0] o_instr, i_mem_wr_data;
  logic [7:0] i_ptr_data, o_tblp, o_tbhp, i_table_high_byte_data, o_table_high_byte, hi;
  pmr_tbl_req_t i_tbl_cmd, cmd;
  pmr_tbl_wr_t o_tbl_wr_data;
  int n_errors = 0, check_count = 0, t, mem [4096];
  integer seed = 32'hd66e8bfa;

  pmr_top u_pmr_top (.*);
  pmr_core_model u_pmr_core_model (.i_mclk, .i_go(go), .i_dup(dup), .i_cmd(cmd), .i_busy(o_tbl_busy),
    .i_wr(o_tbl_wr), .o_req(i_tbl_req), .o_cmd(i_tbl_cmd));
////////////////////////////////////////
  task automatic step(input int n = 1);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : step
  task automatic mw(input logic [11:0] wa);
    mem[wa] = $random(seed);
    i_mem_wr_addr = wa;
    i_mem_wr_data = mem[wa][15:0];
    i_mem_wr_en = 1;
    step();
    i_mem_wr_en = 0;
    step();
  endtask : mw
  task automatic tread(input logic [1:0] op, input logic [7:0] lo);
    hi = $random(seed);
    a = {op[0] ? 4'hf : hi[3:0], lo};
    mw(a);
    i_ptr_data = lo;
    i_tblp_wr = 1;
    step();
    i_tblp_wr = 0;
    i_ptr_data = hi;
    i_tbhp_wr = 1;
    step();
    i_tbhp_wr = 0;
    `CHK("tblp", lo, o_tblp)
    `CHK("tbhp", hi, o_tbhp)
    cmd = {op, 3'($random(seed)), 8'($random(seed))};
    dup = $random(seed);
    go = 1;
    step();
    go = 0;
    for (t = 0; o_tbl_wr !== 1'b1 && t < 9; t++) step();
    `CHK("lat", PMR_TBL_CYCLES, t)
    `CHK("low", mem[a][7:0], o_tbl_wr_data.data)
    `CHK("high", mem[a][15:8], o_table_high_byte)
    `CHK("dest", cmd.dest_addr, o_tbl_wr_data.dest_addr)
    `CHK("far", op[1] && cmd.sector != 3'h0, o_tbl_far)
    step();
    `CHK("refuse", 1'b0, o_tbl_wr)
    `CHK("refuse_busy", 1'b0, o_tbl_busy)
  endtask : tread
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
////////////////////////////////////////
  initial begin
    i_mclk = 0;
    forever #10 i_mclk = ~i_mclk;
  end
  initial begin
    #(20 * 4000);
    n_errors++;
    close_out();
  end
  initial begin
    {i_rst_n, i_pc_inc, i_pc_load, i_tblp_wr, i_tbhp_wr, i_table_high_byte_wr, i_mem_wr_en, go, dup} = '0;
    {i_debug_mode, i_prog_mode, i_prog_serial_data, i_prog_serial_clock} = '0;
    {i_prog_drive, i_prog_dout, i_func_dout, i_func_oe} = '0;
    {i_pc_value, i_mem_wr_addr, i_mem_wr_data, i_ptr_data, i_table_high_byte_data, cmd} = '0;
    step(20);
    i_rst_n = 1;
    `CHK("pc_rst", PMR_RESET_VECTOR, o_pc)
    foreach (fa[i]) begin
      mw(fa[i]);
      mw(fa[i] + 12'h1);
      i_pc_value = fa[i];
      i_pc_load = 1;
      step();
      i_pc_load = 0;
      `CHK("pc", fa[i], o_pc)
      step(2);
      `CHK("instr", mem[fa[i]][15:0], o_instr)
      i_pc_inc = 1;
      step();
      i_pc_inc = 0;
      step(2);
      `CHK("instr_inc", mem[fa[i] + 12'h1][15:0], o_instr)
    end
    $display("fetch done");
    for (int k = 0; k < 24; k++) tread(k[1:0], 8'($random(seed)));
    $display("table done");
    i_pc_inc = 1;
    i_rst_n = 0;
    step(2);
    i_rst_n = 1;
    i_pc_inc = 0;
    `CHK("pc_rst2", PMR_RESET_VECTOR, o_pc)
    `CHK("busy_rst2", 1'b0, o_tbl_busy)
    i_table_high_byte_data = $random(seed);
    i_table_high_byte_wr = 1;
    step();
    i_table_high_byte_wr = 0;
    `CHK("table_high_byte_sw", i_table_high_byte_data, o_table_high_byte)
    i_prog_serial_data = 1;
    i_prog_serial_clock = 1;
    i_prog_drive = 1;
    i_prog_dout = 1'($random(seed));
    i_func_dout = ~i_prog_dout;
    i_func_oe = 0;
    i_debug_mode = 1;
    step(2);
    `CHK("mute", 1'b0, o_func_din)
    `CHK("mute_clk", 1'b0, o_func_clk_din)
    `CHK("clk_seen", 1'b1, o_prog_clk_seen)
    `CHK("dbg_out", i_prog_dout, o_prog_serial_data)
    `CHK("dbg_oe", 1'b1, o_prog_serial_data_oe)
    i_debug_mode = 0;
    i_func_oe = 1;
    step(2);
    `CHK("pass", 1'b1, o_func_din)
    `CHK("pass_clk", 1'b1, o_func_clk_din)
    `CHK("func_out", i_func_dout, o_prog_serial_data)
    `CHK("func_oe", 1'b1, o_prog_serial_data_oe)
    `CHK("clk_idle", 1'b0, o_prog_clk_seen)
    i_func_oe = 0;
    i_prog_drive = 0;
    i_prog_mode = 1;
    step(2);
    `CHK("prog_mute", 1'b0, o_func_din)
    `CHK("prog_clk", 1'b1, o_prog_clk_seen)
    `CHK("prog_oe", 1'b0, o_prog_serial_data_oe)
    `CHK("prog_out", i_prog_dout, o_prog_serial_data)
    i_prog_mode = 0;
    $display("pins done");
    close_out();
  end
endmodule : test_program_memory_table_reader
